// *** design/pcfu_clk_switch.sv ***
`include "pcfu_params.svh"

module pcfu_clk_switch
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Request
  input wire logic i_want_loop,
  // Gate controls
  output logic o_osc_gate,
  output logic o_loop_gate,
  output logic o_sel_loop
);

  localparam logic [3:0] GAP = 4'(`PCFU_SWITCH_GAP_CYC);

  pcfu_pkg::pcfu_sw_state_t state_ff;
  pcfu_pkg::pcfu_sw_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;

  // Break before make: old clock gated off, gap, then new one on
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = 4'h0;
    case (state_ff)
      pcfu_pkg::PCFU_SW_RUN_OSC:
        if (i_want_loop)
          nxt_state = pcfu_pkg::PCFU_SW_GAP_TO_LOOP;
      pcfu_pkg::PCFU_SW_GAP_TO_LOOP:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == GAP - 4'h1)
          nxt_state = pcfu_pkg::PCFU_SW_RUN_LOOP;
      end
      pcfu_pkg::PCFU_SW_RUN_LOOP:
        if (!i_want_loop)
          nxt_state = pcfu_pkg::PCFU_SW_GAP_TO_OSC;
      default:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == GAP - 4'h1)
          nxt_state = pcfu_pkg::PCFU_SW_RUN_OSC;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      state_ff <= pcfu_pkg::PCFU_SW_RUN_OSC;
      cnt_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_osc_gate = (state_ff == pcfu_pkg::PCFU_SW_RUN_OSC);
  assign o_loop_gate = (state_ff == pcfu_pkg::PCFU_SW_RUN_LOOP);
  assign o_sel_loop = (state_ff == pcfu_pkg::PCFU_SW_GAP_TO_LOOP) ||
                      (state_ff == pcfu_pkg::PCFU_SW_RUN_LOOP);

endmodule

// *** design/pcfu_feed.sv ***
`include "pcfu_params.svh"

module pcfu_feed
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Bus cycle view
  input wire logic i_bus_cycle,
  input wire logic i_feed_wr,
  input wire logic [7:0] i_wdata,
  // Result
  output logic o_feed_ok
);

  pcfu_pkg::pcfu_feed_state_t state_ff;
  pcfu_pkg::pcfu_feed_state_t nxt_state;
  logic nxt_ok;

  always_comb
  begin
    nxt_state = pcfu_pkg::PCFU_FEED_IDLE;
    nxt_ok = 1'b0;
    if (i_bus_cycle && i_feed_wr)
    begin
      case (state_ff)
        pcfu_pkg::PCFU_FEED_IDLE:
        begin
          if (i_wdata == `PCFU_FEED_FIRST)
            nxt_state = pcfu_pkg::PCFU_FEED_GOT_FIRST;
        end
        default:
        begin
          nxt_ok = (i_wdata == `PCFU_FEED_SECOND);
        end
      endcase
    end
    else if (!i_bus_cycle)
    begin
      // Idle clocks are not bus cycles and keep the sequence alive
      nxt_state = state_ff;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      state_ff <= pcfu_pkg::PCFU_FEED_IDLE;
      o_feed_ok <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      o_feed_ok <= nxt_ok;
    end
  end

endmodule

// *** design/pcfu_params.svh ***
`ifndef PCFU_PARAMS_SVH
`define PCFU_PARAMS_SVH

// Register byte addresses
`define PCFU_ADDR_CTRL 32'he01fc080
`define PCFU_ADDR_CFG 32'he01fc084
`define PCFU_ADDR_STAT 32'he01fc088
`define PCFU_ADDR_FEED 32'he01fc08c

// Field positions
`define PCFU_CTRL_EN_BIT 0
`define PCFU_CTRL_CON_BIT 1
`define PCFU_CFG_MSEL_LSB 0
`define PCFU_CFG_PSEL_LSB 5
`define PCFU_STAT_EN_BIT 8
`define PCFU_STAT_CON_BIT 9
`define PCFU_STAT_LOCK_BIT 10

// Reset values
`define PCFU_CTRL_RST 2'h0
`define PCFU_MSEL_RST 5'h00
`define PCFU_PSEL_RST 2'h0

// Unlock bytes
`define PCFU_FEED_FIRST 8'haa
`define PCFU_FEED_SECOND 8'h55

// Timing
`define PCFU_CLK_PERIOD_NS 25
`define PCFU_SWITCH_GAP_NS 100
`define PCFU_SWITCH_GAP_CYC \
  ((`PCFU_SWITCH_GAP_NS + `PCFU_CLK_PERIOD_NS - 1) / `PCFU_CLK_PERIOD_NS)

`endif

// *** design/pcfu_pkg.sv ***
package pcfu_pkg;

  typedef enum logic {PCFU_FEED_IDLE, PCFU_FEED_GOT_FIRST} pcfu_feed_state_t;

  typedef enum logic [1:0]
  {
    PCFU_SW_RUN_OSC,
    PCFU_SW_GAP_TO_LOOP,
    PCFU_SW_RUN_LOOP,
    PCFU_SW_GAP_TO_OSC
  } pcfu_sw_state_t;

endpackage

// *** design/pcfu_top.sv ***
// Functional notes
// - Control writes held until valid unlock
// - Active enable powers loop toward lock
// - Loop clock only when enable and connect
// - Connect without enable acts as off
// - Clock changeover is glitch free
// - No lock check, no auto disconnect
// - Config writes held until valid unlock
// - Multiplier bits 4:0, divider bits 6:5
// - Status shows active multiplier and divider
// - Status 8,9 active bits, cleared on power-down
// - Status bit 10 is lock flag
// - Lock flag drives interrupt source
// - Unlock is 0xAA then 0x55
// - Feed writes on consecutive bus cycles
// - Bad feed leaves active state unchanged
// - Power-down disables loop, no restore
// - Multiplier field is factor minus one
// - Divider field encodes 1,2,4,8
`include "pcfu_params.svh"

module pcfu_top
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Peripheral bus
  input wire logic i_bus_valid,
  input wire logic i_bus_write,
  input wire logic [31:0] i_bus_addr,
  input wire logic [7:0] i_bus_wdata,
  output logic [15:0] o_bus_rdata,
  output logic o_bus_rvalid,
  // Power control
  input wire logic i_pd_entry,
  // Analog loop
  input wire logic i_loop_lock,
  output logic o_loop_power,
  output logic [5:0] o_mult_factor,
  output logic [3:0] o_div_factor,
  // Clock selection
  output logic o_osc_gate,
  output logic o_loop_gate,
  output logic o_sel_loop,
  // Interrupt source
  output logic o_lock_irq
);

  function automatic logic [5:0] mult_of(input logic [4:0] f);
    mult_of = {1'b0, f} + 6'h01;
  endfunction

  function automatic logic [3:0] div_of(input logic [1:0] f);
    div_of = 4'h1 << f;
  endfunction

  logic ctrl_en_hold_ff;
  logic ctrl_con_hold_ff;
  logic [4:0] msel_hold_ff;
  logic [1:0] psel_hold_ff;
  logic en_ff;
  logic con_ff;
  logic [4:0] msel_ff;
  logic [1:0] psel_ff;
  logic lock_s1_ff;
  logic lock_s2_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic nxt_en;
  logic nxt_con;
  logic feed_ok;

  // Address decode
  wire hit_ctrl = (i_bus_addr == `PCFU_ADDR_CTRL);
  wire hit_cfg = (i_bus_addr == `PCFU_ADDR_CFG);
  wire hit_stat = (i_bus_addr == `PCFU_ADDR_STAT);
  wire hit_feed = (i_bus_addr == `PCFU_ADDR_FEED);
  wire wr = i_bus_valid && i_bus_write;
  wire rd = i_bus_valid && !i_bus_write;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_cfg = wr && hit_cfg;
  wire wr_feed = wr && hit_feed;

  // Read mux; reserved bits and unmapped space read zero
  logic [15:0] status_word;
  logic [15:0] rd_word;
  assign status_word = {5'h00, lock_s2_ff, con_ff, en_ff, 1'b0,
                        psel_ff, msel_ff};
  assign rd_word = hit_ctrl ? {14'h0000, ctrl_con_hold_ff, ctrl_en_hold_ff}
                 : hit_cfg ? {9'h000, psel_hold_ff, msel_hold_ff}
                 : hit_stat ? status_word
                 : 16'h0000;

  // Lock pin comes from the analog loop, asynchronous
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end
    else
    begin
      lock_s1_ff <= i_loop_lock;
      lock_s2_ff <= lock_s1_ff;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      {ctrl_con_hold_ff, ctrl_en_hold_ff} <= `PCFU_CTRL_RST;
      msel_hold_ff <= `PCFU_MSEL_RST;
      psel_hold_ff <= `PCFU_PSEL_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_en_hold_ff <= i_bus_wdata[`PCFU_CTRL_EN_BIT];
        ctrl_con_hold_ff <= i_bus_wdata[`PCFU_CTRL_CON_BIT];
      end
      if (wr_cfg)
      begin
        msel_hold_ff <= i_bus_wdata[`PCFU_CFG_MSEL_LSB +: 5];
        psel_hold_ff <= i_bus_wdata[`PCFU_CFG_PSEL_LSB +: 2];
      end
    end
  end

  pcfu_feed u_feed
  (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_bus_cycle(i_bus_valid),
    .i_feed_wr(wr_feed),
    .i_wdata(i_bus_wdata),
    .o_feed_ok(feed_ok)
  );

  // power-down clears and beats a same-cycle feed
  always_comb
  begin
    nxt_en = en_ff;
    nxt_con = con_ff;
    if (i_pd_entry)
    begin
      nxt_en = 1'b0;
      nxt_con = 1'b0;
    end
    else if (feed_ok)
    begin
      nxt_en = ctrl_en_hold_ff;
      nxt_con = ctrl_con_hold_ff;
    end
  end

  // active shadow moves on a good feed; power-down also clears en and con
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      en_ff <= 1'b0;
      con_ff <= 1'b0;
      msel_ff <= `PCFU_MSEL_RST;
      psel_ff <= `PCFU_PSEL_RST;
    end
    else
    begin
      en_ff <= nxt_en;
      con_ff <= nxt_con;
      if (feed_ok)
      begin
        msel_ff <= msel_hold_ff;
        psel_ff <= psel_hold_ff;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= rd;
      if (rd)
        rdata_ff <= rd_word;
    end
  end

  assign o_bus_rdata = rdata_ff;
  assign o_bus_rvalid = rvalid_ff;

  assign o_loop_power = en_ff;
  assign o_mult_factor = mult_of(msel_ff);
  assign o_div_factor = div_of(psel_ff);
  assign o_lock_irq = lock_s2_ff;

  // connect needs both bits, lock ignored
  wire want_loop = en_ff && con_ff;

  pcfu_clk_switch u_switch
  (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_want_loop(want_loop),
    .o_osc_gate(o_osc_gate),
    .o_loop_gate(o_loop_gate),
    .o_sel_loop(o_sel_loop)
  );

  // Helper: track feed pattern for checking
  logic aa_seen_ff;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      aa_seen_ff <= 1'b0;
    else if (i_bus_valid)
      aa_seen_ff <= wr_feed && (i_bus_wdata == `PCFU_FEED_FIRST) &&
                    !aa_seen_ff;
  end

  AST_FEED_APPLIES:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (aa_seen_ff && wr_feed && i_bus_wdata == `PCFU_FEED_SECOND) ##1
    !i_pd_entry |=> (en_ff == $past(ctrl_en_hold_ff, 2) &&
    msel_ff == $past(msel_hold_ff, 2)))
  else $error("good feed did not load active state");

  AST_ACTIVE_STABLE:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (!feed_ok && !i_pd_entry) |=> ($stable(en_ff) && $stable(con_ff) &&
     $stable(msel_ff) && $stable(psel_ff)))
  else $error("active state changed without good feed");

  AST_FEED_ORDER:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    feed_ok |-> $past(aa_seen_ff) &&
    $past(i_bus_wdata) == `PCFU_FEED_SECOND && $past(wr_feed))
  else $error("feed accepted out of order");

  AST_INTERVENING:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (aa_seen_ff && i_bus_valid && !wr_feed) |=> !feed_ok)
  else $error("feed accepted across another bus cycle");

  AST_PD_CLEARS:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_pd_entry |=> (!en_ff && !con_ff && !o_loop_power))
  else $error("power-down left loop enabled");

  AST_CONNECT_NEEDS_EN:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_loop_gate |-> en_ff || $past(en_ff))
  else $error("loop clock gated in while disabled");

  AST_NO_OVERLAP:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $fell(o_osc_gate) |-> !o_loop_gate [*4])
  else $error("clock gates overlap during changeover");

  AST_LOCK_LATENCY:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(i_loop_lock) ##1 i_loop_lock |=> o_lock_irq)
  else $error("lock flag not seen after two cycles");

  AST_STATUS_READ:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (rd && hit_stat) |=> o_bus_rvalid &&
    o_bus_rdata == $past(status_word))
  else $error("status read returned wrong word");

  AST_SWITCH_BOUND:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (want_loop && o_osc_gate) |-> ##[1:8] (o_loop_gate || !want_loop))
  else $error("loop clock not selected in time");

  AST_RESERVED_ZERO:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    rd |=> (o_bus_rdata[15:11] == 5'h00 && !o_bus_rdata[7]))
  else $error("reserved read bits not zero");

  AST_RVALID_PULSE:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_bus_rvalid |-> $past(rd))
  else $error("read valid without a read");

  AST_LOAD_CONFIG:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    feed_ok |=> (msel_ff == $past(msel_hold_ff) &&
    psel_ff == $past(psel_hold_ff)))
  else $error("good feed did not load configuration");

  AST_CONFIG_HELD:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (wr_cfg && !feed_ok) |=> ($stable(msel_ff) && $stable(psel_ff)))
  else $error("configuration write reached active state");

  AST_MAKE_AFTER_BREAK:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(o_loop_gate) |-> ($past(o_sel_loop) && !$past(o_osc_gate)))
  else $error("loop clock gated in before changeover gap");

  AST_NO_DISCONNECT:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (want_loop && o_loop_gate && $fell(o_lock_irq)) |=> o_loop_gate)
  else $error("loop disconnected on loss of lock");

  AST_MULT_RANGE:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (o_mult_factor != 6'h00) && (o_mult_factor <= 6'h20))
  else $error("multiplier factor outside 1 to 32");

  AST_DIV_ONEHOT:
  assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $onehot(o_div_factor))
  else $error("divider factor not a power of two");

  COV_FEED: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    feed_ok);
  COV_SWITCH_LOOP: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) $rose(o_loop_gate));
  COV_PD: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_pd_entry && o_loop_gate);
  COV_LOCK_LOST: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) $fell(o_lock_irq) && o_loop_gate);
  COV_FEED_BROKEN: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) aa_seen_ff && i_bus_valid && !wr_feed);

endmodule

// *** tb/pcfu_top_test.sv ***
`include "pcfu_params.svh"

module pcfu_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_bus_valid = 1'b0;
  logic i_bus_write = 1'b0;
  logic [31:0] i_bus_addr = 32'h0;
  logic [7:0] i_bus_wdata = 8'h00;
  logic i_pd_entry = 1'b0;
  logic i_loop_lock = 1'b0;
  logic [15:0] o_bus_rdata;
  logic o_bus_rvalid;
  logic o_loop_power;
  logic [5:0] o_mult_factor;
  logic [3:0] o_div_factor;
  logic o_osc_gate;
  logic o_loop_gate;
  logic o_sel_loop;
  logic o_lock_irq;
  int fails = 0;
  int total_checks = 0;
  int seed = 19;
  logic [4:0] m;
  logic [1:0] p;
  logic [4:0] am = 5'h00;
  logic [1:0] ap = 2'h0;

  pcfu_top DUT
  (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_bus_valid(i_bus_valid),
    .i_bus_write(i_bus_write),
    .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(o_bus_rdata),
    .o_bus_rvalid(o_bus_rvalid),
    .i_pd_entry(i_pd_entry),
    .i_loop_lock(i_loop_lock),
    .o_loop_power(o_loop_power),
    .o_mult_factor(o_mult_factor),
    .o_div_factor(o_div_factor),
    .o_osc_gate(o_osc_gate),
    .o_loop_gate(o_loop_gate),
    .o_sel_loop(o_sel_loop),
    .o_lock_irq(o_lock_irq)
  );

  initial
  begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task report_and_stop;
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      fails++;
    end
  endtask

  function logic [15:0] stat_of(logic [4:0] fm, logic [1:0] fp, logic en,
                                logic con, logic lk);
    return {5'h00, lk, con, en, 1'b0, fp, fm};
  endfunction

  // Requests launch after an edge and are taken at the next one
  task cyc(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus_valid <= 1'b1;
    i_bus_write <= w;
    i_bus_addr <= a;
    i_bus_wdata <= d;
  endtask

  task idle(input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys);
      i_bus_valid <= 1'b0;
    end
  endtask

  task rd(input logic [31:0] a, input logic [15:0] exp);
    cyc(a, 1'b0, 8'h00);
    idle(1);
    #1;
    chk({o_bus_rvalid, o_bus_rdata}, {1'b1, exp}, "read data");
  endtask

  // Active state lands two edges after the second byte
  task feed(input logic [7:0] a, input logic [7:0] b, input logic gap);
    cyc(`PCFU_ADDR_FEED, 1'b1, a);
    if (gap)
      cyc(`PCFU_ADDR_STAT, 1'b0, 8'h00);
    cyc(`PCFU_ADDR_FEED, 1'b1, b);
    idle(3);
  endtask

  task wait_gate(input logic lv);
    int n;
    n = 0;
    #1;
    while (!(o_loop_gate === lv && o_osc_gate === !lv) && n < 20)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (!(o_loop_gate === lv && o_osc_gate === !lv))
    begin
      $display("wrong value at %0t: clock switch stuck", $time);
      fails++;
      report_and_stop();
    end
  endtask

  // Both gates open at once would be a glitch
  always @(negedge i_clk_sys)
  begin
    if (i_nrst)
      chk(17'({o_osc_gate & o_loop_gate, o_loop_gate & ~o_sel_loop}), 17'h0,
          "gate overlap");
  end

  initial
  begin
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    chk(17'({o_osc_gate, o_loop_gate, o_sel_loop, o_loop_power}), 17'h8,
        "reset gates");
    chk(17'({o_mult_factor, o_div_factor}), 17'h11, "reset factors");
    rd(`PCFU_ADDR_CTRL, 16'h0000);
    rd(`PCFU_ADDR_CFG, 16'h0000);
    rd(`PCFU_ADDR_STAT, 16'h0000);
    for (int k = 0; k < 6; k++)
    begin
      m = (k == 0) ? 5'h1f : (k == 1) ? 5'h00 : 5'($random(seed));
      p = 2'(k);
      cyc(`PCFU_ADDR_CFG, 1'b1, {1'b1, p, m});
      cyc(`PCFU_ADDR_CTRL, 1'b1, 8'hfd);
      idle(1);
      rd(`PCFU_ADDR_STAT, stat_of(am, ap, k > 0, 1'b0, 1'b0));
      feed(8'haa, 8'h55, 1'b0);
      rd(`PCFU_ADDR_STAT, stat_of(m, p, 1'b1, 1'b0, 1'b0));
      chk({6'h0, o_loop_power, o_mult_factor, o_div_factor},
          {6'h0, 1'b1, 6'(m) + 6'h1, 4'h1 << p}, "factors");
      rd(`PCFU_ADDR_CFG, {9'h000, p, m});
      rd(`PCFU_ADDR_CTRL, 16'h0001);
      am = m;
      ap = p;
    end
    rd(32'he01fc090, 16'h0000);
    cyc(`PCFU_ADDR_STAT, 1'b1, 8'hff);
    cyc(`PCFU_ADDR_CFG, 1'b1, 8'h00);
    cyc(`PCFU_ADDR_CTRL, 1'b1, 8'h00);
    feed(8'haa, 8'h55, 1'b1);
    // Order matters: idle clocks keep a pending first byte alive
    feed(8'haa, 8'h54, 1'b0);
    feed(8'haa, 8'haa, 1'b0);
    feed(8'h55, 8'h00, 1'b0);
    feed(8'h55, 8'haa, 1'b0);
    rd(`PCFU_ADDR_STAT, stat_of(am, ap, 1'b1, 1'b0, 1'b0));
    cyc(`PCFU_ADDR_CTRL, 1'b1, 8'h02);
    feed(8'haa, 8'h55, 1'b0);
    rd(`PCFU_ADDR_STAT, stat_of(5'h00, 2'h0, 1'b0, 1'b1, 1'b0));
    chk(17'({o_loop_power, o_sel_loop, o_osc_gate}), 17'h1, "bypass");
    cyc(`PCFU_ADDR_CTRL, 1'b1, 8'h01);
    feed(8'haa, 8'h55, 1'b0);
    i_loop_lock <= 1'b1;
    idle(4);
    #1;
    chk(17'(o_lock_irq), 17'h1, "lock irq");
    rd(`PCFU_ADDR_STAT, stat_of(5'h00, 2'h0, 1'b1, 1'b0, 1'b1));
    cyc(`PCFU_ADDR_CTRL, 1'b1, 8'h03);
    feed(8'haa, 8'h55, 1'b0);
    wait_gate(1'b1);
    chk(17'({o_sel_loop, o_loop_power}), 17'h3, "loop selected");
    @(posedge i_clk_sys);
    i_loop_lock <= 1'b0;
    idle(5);
    #1;
    chk(17'({o_lock_irq, o_loop_gate}), 17'h1, "lock lost");
    @(posedge i_clk_sys);
    i_pd_entry <= 1'b1;
    @(posedge i_clk_sys);
    i_pd_entry <= 1'b0;
    #1;
    chk(17'(o_loop_power), 17'h0, "power down");
    wait_gate(1'b0);
    rd(`PCFU_ADDR_STAT, stat_of(5'h00, 2'h0, 1'b0, 1'b0, 1'b0));
    rd(`PCFU_ADDR_CTRL, 16'h0003);
    // Wakeup: enable alone, status then shows loop powered but not connected
    cyc(`PCFU_ADDR_CTRL, 1'b1, 8'h01);
    feed(8'haa, 8'h55, 1'b0);
    rd(`PCFU_ADDR_STAT, stat_of(5'h00, 2'h0, 1'b1, 1'b0, 1'b0));
    report_and_stop();
  end
endmodule
